//--- ctv_chk.sv
// ctv_chk: port-level assertions for ctv_top.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module ctv_chk
  import ctv_pkg::*;
#(
  parameter int FIFOS = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic sof_sample,
  input wire logic fd_res_sample,
  input wire logic rx_frame_valid,
  input wire logic tx_frame_valid,
  input wire logic [FIFOS-1:0] receive_fifo_flags,
  input wire logic [FIFOS-1:0] transmit_fifo_flags,
  input wire logic [CTV_CAUSES-1:0] cause_flags,
  input wire logic overflow_clear,
  input wire logic stamp_strobe_q,
  input wire logic time_base_overflow_flag_q,
  input wire logic [31:0] vector_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////
  // any frame event, whichever stamping point is selected
  logic any_event;
  assign any_event = sof_sample | fd_res_sample | rx_frame_valid
                   | tx_frame_valid;
  // nothing pending anywhere, so every code field must read idle
  sequence s_all_quiet;
    ce && receive_fifo_flags == '0 && transmit_fifo_flags == '0
      && cause_flags == '0 && !time_base_overflow_flag_q;
  endsequence
  sequence s_strobe_alone;
    ce && stamp_strobe_q && !any_event;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  property p_strobe_src;
    $past(ce) && stamp_strobe_q |-> $past(any_event);
  endproperty
  a_strobe_src: assert property (p_strobe_src)
    else $error("stamp strobe without a frame event");
  property p_strobe_pulse;
    s_strobe_alone |=> !stamp_strobe_q;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("stamp strobe longer than one cycle");
  property p_idle_code;
    s_all_quiet |=> vector_q == 32'h40400040;
  endproperty
  a_idle_code: assert property (p_idle_code)
    else $error("idle vector wrong");
  property p_rx_none;
    ce && receive_fifo_flags[FIFOS-1:1] == '0 |=>
      vector_q[30:24] == CTV_CODE_NONE;
  endproperty
  a_rx_none: assert property (p_rx_none)
    else $error("receive code not idle");
  property p_rx_top;
    ce && receive_fifo_flags[FIFOS-1] |=> vector_q[30:24] == 7'h1f;
  endproperty
  a_rx_top: assert property (p_rx_top)
    else $error("receive code not highest fifo");
  property p_txq;
    ce && transmit_fifo_flags == FIFOS'(1) |=> vector_q[22:16] == 7'h00;
  endproperty
  a_txq: assert property (p_txq)
    else $error("transmit queue code wrong");
  property p_cause_top;
    ce && cause_flags[CTV_CAUSES-1] |=> vector_q[6:0] == 7'h4a;
  endproperty
  a_cause_top: assert property (p_cause_top)
    else $error("transmit attempt code wrong");
  property p_ovf_code;
    ce && time_base_overflow_flag_q && cause_flags[9:6] == '0 |=>
      vector_q[6:0] == 7'h46;
  endproperty
  a_ovf_code: assert property (p_ovf_code)
    else $error("overflow code not shown");
  property p_ovf_hold;
    ce && time_base_overflow_flag_q && !overflow_clear |=>
      time_base_overflow_flag_q;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow flag dropped by itself");
  property p_rsv_zero;
    (vector_q & 32'h8080e080) == 32'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved vector bits set");
endmodule : ctv_chk

bind ctv_top ctv_chk #(.FIFOS(FIFOS)) u_chk (.clock, .sys_rst, .ce,
  .sof_sample, .fd_res_sample, .rx_frame_valid, .tx_frame_valid,
  .receive_fifo_flags, .transmit_fifo_flags, .cause_flags,
  .overflow_clear, .stamp_strobe_q, .time_base_overflow_flag_q, .vector_q);
`default_nettype wire

//--- ctv_frame_model.sv
// ctv_frame_model: stands in for the protocol engine beside the block.
// assumes the bench holds req for exactly one clock per event.
`timescale 1ns/100ps
`default_nettype none
module ctv_frame_model (
  input wire logic req,
  input wire logic [2:0] kind,
  input wire logic [5:0] delay,
  output logic sof_sample,
  output logic fd_res_sample,
  output logic rx_frame_valid,
  output logic tx_frame_valid,
  output logic measure_strobe,
  output logic [5:0] measured_delay
);
  // one single-cycle pulse per event kind
  assign sof_sample = req && kind == 3'h0;
  assign fd_res_sample = req && kind == 3'h1;
  assign rx_frame_valid = req && kind == 3'h2;
  assign tx_frame_valid = req && kind == 3'h3;
  assign measure_strobe = req && kind == 3'h4;
  // off-strobe the delay bus shows garbage, never a held value
  assign measured_delay = measure_strobe ? delay : ~delay;
endmodule : ctv_frame_model
`default_nettype wire

//--- ctv_pkg.sv
// ctv_pkg: register offsets, field positions, reset values and cause codes
// for the delay compensation, time base and cause vector slice.
// assumes word-wide register accesses on a 4-bit byte address.
package ctv_pkg;

  // register byte addresses
  localparam logic [3:0] CTV_OFS_TDC = 4'h0;
  localparam logic [3:0] CTV_OFS_TBC = 4'h4;
  localparam logic [3:0] CTV_OFS_TSCON = 4'h8;
  localparam logic [3:0] CTV_OFS_VEC = 4'hc;

  // delay compensation register fields
  localparam int CTV_TDC_EDGE_BIT = 25;
  localparam int CTV_TDC_SID_BIT = 24;
  localparam int CTV_TDC_MODE_LSB = 16;
  localparam int CTV_TDC_OFS_LSB = 8;
  localparam int CTV_TDC_VAL_LSB = 0;
  localparam logic [1:0] CTV_TDC_MODE_RST = 2'h2;
  localparam logic [6:0] CTV_TDC_OFS_RST = 7'h10;
  localparam logic [5:0] CTV_TDC_VAL_RST = 6'h00;

  // time stamp control fields
  localparam int CTV_TS_RES_BIT = 18;
  localparam int CTV_TS_EOF_BIT = 17;
  localparam int CTV_TS_EN_BIT = 16;
  localparam int CTV_TS_PRE_LSB = 0;
  localparam logic [9:0] CTV_TS_PRE_RST = 10'h000;

  // cause vector fields
  localparam int CTV_VEC_RX_LSB = 24;
  localparam int CTV_VEC_TX_LSB = 16;
  localparam int CTV_VEC_FIL_LSB = 8;
  localparam int CTV_VEC_ALL_LSB = 0;
  localparam logic [6:0] CTV_CODE_NONE = 7'h40;
  localparam logic [6:0] CTV_CODE_CAUSE_BASE = 7'h41;
  localparam int CTV_CAUSES = 10;
  localparam int CTV_CAUSE_TBC_IDX = 5;

  // delay compensation modes
  typedef enum logic [1:0] {
    CTV_MODE_OFF,
    CTV_MODE_MANUAL,
    CTV_MODE_AUTO,
    CTV_MODE_AUTO_ALT
  } ctv_mode_t;

endpackage : ctv_pkg

//--- ctv_prio_enc.sv
// ctv_prio_enc: reports the index of the highest set bit of a flag vector.
// assumes flags are stable levels; output is combinational.
`timescale 1ns/100ps
`default_nettype none
module ctv_prio_enc #(
  parameter int N = 32
) (
  input wire logic [N-1:0] flags,
  output logic any,
  output logic [$clog2(N)-1:0] idx
);
  if (N < 2) begin : g_bad_n
    $error("ctv_prio_enc needs at least two flags");
  end

  // upward scan so the last hit, the highest number, wins
  always_comb begin
    idx = '0;
    for (int i = 0; i < N; i++) begin
      if (flags[i]) idx = i[$clog2(N)-1:0];
    end
  end
  assign any = |flags;
endmodule : ctv_prio_enc
`default_nettype wire

//--- ctv_tb_if.sv
// ctv_tb_if: carries control and state between the register logic and the
// time base counter. assumes both ends share one clock.
`timescale 1ns/100ps
`default_nettype none
interface ctv_tb_if;
  logic enable;
  logic [9:0] prescale;
  logic load;
  logic [31:0] load_value;
  logic [31:0] count;
  logic wrap;
  modport ctl (output enable, prescale, load, load_value, input count, wrap);
  modport tb (input enable, prescale, load, load_value, output count, wrap);
endinterface : ctv_tb_if
`default_nettype wire

//--- ctv_time_base.sv
// ctv_time_base: free running 32-bit counter behind a 10-bit prescaler.
// assumes load is a one-cycle pulse from a register write.
`timescale 1ns/100ps
`default_nettype none
module ctv_time_base (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  ctv_tb_if.tb tb
);
  logic [9:0] pre_q;
  logic [31:0] cnt_q;
  logic wrap_q;
  logic tick;

  assign tick = (pre_q == tb.prescale);
  assign tb.count = cnt_q;
  assign tb.wrap = wrap_q;

  // disabled counter is held at zero, not just frozen
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pre_q <= 10'h000;
      cnt_q <= 32'h0000_0000;
      wrap_q <= 1'b0;
    end else if (ce) begin
      wrap_q <= 1'b0;
      if (!tb.enable) begin
        pre_q <= 10'h000;
        cnt_q <= 32'h0000_0000;
      end else if (tb.load) begin
        pre_q <= 10'h000;
        cnt_q <= tb.load_value;
      end else if (tick) begin
        pre_q <= 10'h000;
        cnt_q <= cnt_q + 32'h0000_0001;
        wrap_q <= (cnt_q == 32'hffff_ffff);
      end else begin
        pre_q <= pre_q + 10'h001;
      end
    end
  end
endmodule : ctv_time_base
`default_nettype wire

//--- ctv_top.sv
// ctv_top: delay compensation setup, time base and time stamp capture,
// and the read-only interrupt cause vector of a can fd controller.
// assumes a host-side register port (from the serial front end), frame
// event pulses from the protocol engine, and fifo/cause flags as levels.
//
// Contract
// - edge filter enable bit drives edge filtering during bus integration.
// - twelve-bit id enable makes RRS an extra id lsb in fd base frames.
// - mode 1x auto measures plus offset, 01 register plus offset, 00 off.
// - offset is seven-bit two's complement clock periods, -64 to +63.
// - value is unsigned delay of 0 to 63 clock periods.
// - compensation register is writable only in configuration mode.
// - 32-bit counter runs while enabled, one step per prescaled period.
// - clearing the enable stops the counter and zeroes it.
// - any counter register write restarts the prescaler count only; here a write while enabled also loads the written value.
// - prescale setting n gives one increment every n plus one clocks.
// - fd frames stamp after fdf bit when selected, otherwise at sof.
// - end-of-frame stamping captures when the frame becomes valid.
// - without end-of-frame stamping classical frames stamp at sof.
// - receive code names highest flagged fifo 1..31, else 1000000.
// - transmit code names queue 0 or fifo 1..31, else 1000000.
// - filter hit field gives the filter matching the reported message.
// - each code field shows the highest-numbered pending source.
// - unimplemented bits read zero and ignore writes.
// - overall code encodes active cause, 1000000 meaning none.
// - overflow flag sets on counter wrap and holds until cleared.
`timescale 1ns/100ps
`default_nettype none
module ctv_top
  import ctv_pkg::*;
#(
  parameter int FIFOS = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic config_mode,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_q,
  input wire logic [5:0] measured_delay,
  input wire logic measure_strobe,
  input wire logic sof_sample,
  input wire logic fd_res_sample,
  input wire logic rx_frame_valid,
  input wire logic tx_frame_valid,
  input wire logic [FIFOS-1:0] receive_fifo_flags,
  input wire logic [FIFOS-1:0] transmit_fifo_flags,
  input wire logic [FIFOS*5-1:0] fifo_filter_hits,
  input wire logic [CTV_CAUSES-1:0] cause_flags,
  input wire logic overflow_clear,
  output logic edge_filter_enable_q,
  output logic twelve_bit_base_id_enable_q,
  output logic ssp_enable_q,
  output logic [6:0] secondary_sample_point_q,
  output logic [31:0] timestamp_q,
  output logic stamp_strobe_q,
  output logic time_base_overflow_flag_q,
  output logic [31:0] vector_q
);

  if (FIFOS != 32) begin : g_bad_fifos
    $error("ctv_top codes assume exactly 32 fifos");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  logic sel_tdc;
  logic sel_tbc;
  logic sel_tscon;
  logic sel_vec;
  logic wr_tdc;
  logic wr_tbc;
  logic wr_tscon;

  // writes to the compensation register outside config mode are dropped
  assign sel_tdc = (reg_addr == CTV_OFS_TDC);
  assign sel_tbc = (reg_addr == CTV_OFS_TBC);
  assign sel_tscon = (reg_addr == CTV_OFS_TSCON);
  assign sel_vec = (reg_addr == CTV_OFS_VEC);
  assign wr_tdc = reg_wr && sel_tdc && config_mode;
  assign wr_tbc = reg_wr && sel_tbc;
  assign wr_tscon = reg_wr && sel_tscon;

  ////////////////////////////////////////////////////////////////////////////
  // delay compensation register

  logic edge_en_q;
  logic sid12_en_q;
  logic [1:0] mode_q;
  logic [6:0] ofs_q;
  logic [5:0] val_q;
  logic auto_mode;

  // both auto codes behave alike; bit one alone decides measuring
  assign auto_mode = mode_q[1];

  // measurements land in auto mode, config mode or not; in the same cycle
  // a measurement beats a software write of the value field
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      edge_en_q <= 1'b0;
      sid12_en_q <= 1'b0;
      mode_q <= CTV_TDC_MODE_RST;
      ofs_q <= CTV_TDC_OFS_RST;
      val_q <= CTV_TDC_VAL_RST;
    end else if (ce) begin
      if (wr_tdc) begin
        edge_en_q <= reg_wdata[CTV_TDC_EDGE_BIT];
        sid12_en_q <= reg_wdata[CTV_TDC_SID_BIT];
        mode_q <= reg_wdata[CTV_TDC_MODE_LSB +: 2];
        ofs_q <= reg_wdata[CTV_TDC_OFS_LSB +: 7];
        val_q <= reg_wdata[CTV_TDC_VAL_LSB +: 6];
      end
      if (auto_mode && measure_strobe) begin
        val_q <= measured_delay;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // secondary sample point placement

  logic signed [7:0] ssp_sum;
  logic [6:0] ssp_pos_d;
  logic ssp_en_d;

  // value zero-extended, offset sign-extended: range -64 .. 126
  assign ssp_sum = $signed({2'b00, val_q}) + $signed({ofs_q[6], ofs_q});
  // a negative position cannot be sampled; pin it to the bit start
  assign ssp_pos_d = ssp_sum[7] ? 7'h00 : ssp_sum[6:0];
  assign ssp_en_d = (mode_q != CTV_MODE_OFF);

  // protocol-facing controls, registered so the engine sees clean levels
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      edge_filter_enable_q <= 1'b0;
      twelve_bit_base_id_enable_q <= 1'b0;
      ssp_enable_q <= 1'b0;
      secondary_sample_point_q <= 7'h00;
    end else if (ce) begin
      edge_filter_enable_q <= edge_en_q;
      twelve_bit_base_id_enable_q <= sid12_en_q;
      ssp_enable_q <= ssp_en_d;
      secondary_sample_point_q <= ssp_pos_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time stamp control register

  logic ts_res_q;
  logic ts_eof_q;
  logic tb_en_q;
  logic [9:0] tb_pre_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ts_res_q <= 1'b0;
      ts_eof_q <= 1'b0;
      tb_en_q <= 1'b0;
      tb_pre_q <= CTV_TS_PRE_RST;
    end else if (ce && wr_tscon) begin
      ts_res_q <= reg_wdata[CTV_TS_RES_BIT];
      ts_eof_q <= reg_wdata[CTV_TS_EOF_BIT];
      tb_en_q <= reg_wdata[CTV_TS_EN_BIT];
      tb_pre_q <= reg_wdata[CTV_TS_PRE_LSB +: 10];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time base counter

  ctv_tb_if tb_bus ();

  // while enabled, a counter write loads the value and restarts the prescale count
  assign tb_bus.enable = tb_en_q;
  assign tb_bus.prescale = tb_pre_q;
  assign tb_bus.load = wr_tbc;
  assign tb_bus.load_value = reg_wdata;

  ctv_time_base u_time_base (
    .clock(clock),
    .sys_rst(sys_rst),
    .ce(ce),
    .tb(tb_bus.tb)
  );

  // set beats a clear in the same cycle so no wrap is ever missed
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      time_base_overflow_flag_q <= 1'b0;
    end else if (ce) begin
      if (tb_bus.wrap) begin
        time_base_overflow_flag_q <= 1'b1;
      end else if (overflow_clear) begin
        time_base_overflow_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time stamp capture

  logic stamp_take;
  logic early_take;
  logic late_take;

  // sof stamp is provisional: an fd frame with res stamping overwrites it
  // once the bit after fdf is sampled, since fd is unknown at sof
  assign early_take = sof_sample || (ts_res_q && fd_res_sample);
  assign late_take = rx_frame_valid || tx_frame_valid;
  assign stamp_take = ts_eof_q ? late_take : early_take;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      timestamp_q <= 32'h0000_0000;
      stamp_strobe_q <= 1'b0;
    end else if (ce) begin
      stamp_strobe_q <= stamp_take;
      if (stamp_take) begin
        timestamp_q <= tb_bus.count;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cause vector

  logic rx_any;
  logic [4:0] rx_idx;
  logic tx_any;
  logic [4:0] tx_idx;
  logic fifo_any;
  logic [4:0] fifo_idx;
  logic cause_any;
  logic [3:0] cause_idx;
  logic [CTV_CAUSES-1:0] causes;
  logic [FIFOS-1:0] rx_live;
  logic [6:0] rx_code;
  logic [6:0] tx_code;
  logic [6:0] all_code;
  logic [4:0] fil_hit;
  logic [31:0] vec_d;

  // fifo zero cannot receive, so its receive flag is ignored
  assign rx_live = {receive_fifo_flags[FIFOS-1:1], 1'b0};
  // our own overflow flag feeds its slot among the general causes
  assign causes = cause_flags |
    (CTV_CAUSES'(time_base_overflow_flag_q) << CTV_CAUSE_TBC_IDX);

  ctv_prio_enc #(.N(FIFOS)) u_rx_enc (
    .flags(rx_live),
    .any(rx_any),
    .idx(rx_idx)
  );

  ctv_prio_enc #(.N(FIFOS)) u_tx_enc (
    .flags(transmit_fifo_flags),
    .any(tx_any),
    .idx(tx_idx)
  );

  ctv_prio_enc #(.N(FIFOS)) u_fifo_enc (
    .flags(rx_live | transmit_fifo_flags),
    .any(fifo_any),
    .idx(fifo_idx)
  );

  ctv_prio_enc #(.N(CTV_CAUSES)) u_cause_enc (
    .flags(causes),
    .any(cause_any),
    .idx(cause_idx)
  );

  // each field shows its highest-numbered pending source
  assign rx_code = rx_any ? {2'b00, rx_idx} : CTV_CODE_NONE;
  assign tx_code = tx_any ? {2'b00, tx_idx} : CTV_CODE_NONE;
  // general causes all sit above the fifo codes, so they win first
  assign all_code = cause_any ? CTV_CODE_CAUSE_BASE + {3'b000, cause_idx}
                  : fifo_any ? {2'b00, fifo_idx}
                  : CTV_CODE_NONE;
  // filter number follows the receive fifo that is being reported
  assign fil_hit = fifo_filter_hits[rx_idx*5 +: 5];

  // unimplemented bits tie to zero
  always_comb begin
    vec_d = 32'h0000_0000;
    vec_d[CTV_VEC_RX_LSB +: 7] = rx_code;
    vec_d[CTV_VEC_TX_LSB +: 7] = tx_code;
    vec_d[CTV_VEC_FIL_LSB +: 5] = fil_hit;
    vec_d[CTV_VEC_ALL_LSB +: 7] = all_code;
  end

  // one cycle of latency; the vector is a snapshot, not a live decode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      vector_q <= {1'b0, CTV_CODE_NONE, 1'b0, CTV_CODE_NONE, 8'h00, 1'b0,
                   CTV_CODE_NONE};
    end else if (ce) begin
      vector_q <= vec_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [31:0] tdc_rd;
  logic [31:0] tscon_rd;
  logic [31:0] rd_mux;

  // reserved positions are built as zero, never stored
  always_comb begin
    tdc_rd = 32'h0000_0000;
    tdc_rd[CTV_TDC_EDGE_BIT] = edge_en_q;
    tdc_rd[CTV_TDC_SID_BIT] = sid12_en_q;
    tdc_rd[CTV_TDC_MODE_LSB +: 2] = mode_q;
    tdc_rd[CTV_TDC_OFS_LSB +: 7] = ofs_q;
    tdc_rd[CTV_TDC_VAL_LSB +: 6] = val_q;
    tscon_rd = 32'h0000_0000;
    tscon_rd[CTV_TS_RES_BIT] = ts_res_q;
    tscon_rd[CTV_TS_EOF_BIT] = ts_eof_q;
    tscon_rd[CTV_TS_EN_BIT] = tb_en_q;
    tscon_rd[CTV_TS_PRE_LSB +: 10] = tb_pre_q;
  end

  // unmapped addresses read as zero
  assign rd_mux = sel_tdc ? tdc_rd
                : sel_tbc ? tb_bus.count
                : sel_tscon ? tscon_rd
                : sel_vec ? vector_q
                : 32'h0000_0000;

  // read data holds until the next read
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (ce && reg_rd) begin
      reg_rdata_q <= rd_mux;
    end
  end

endmodule : ctv_top
`default_nettype wire

//--- test_can_fd_tdc_timestamp_vector.sv
// test bench for ctv_top: register sequences with expected values.
// assumes the frame model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module test_can_fd_tdc_timestamp_vector;
  import ctv_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, ce = 1'b1, config_mode = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, req = 1'b0, overflow_clear = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [2:0] kind = 3'h7;
  logic [5:0] delay = 6'h00, measured_delay;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_q, timestamp_q, vector_q;
  logic [31:0] receive_fifo_flags = 32'h0, transmit_fifo_flags = 32'h0;
  logic [159:0] fifo_filter_hits = {5'h0b, 125'h0, 5'h11, 25'h0};
  logic [9:0] cause_flags = 10'h000;
  logic measure_strobe, sof_sample, fd_res_sample, rx_frame_valid;
  logic tx_frame_valid, edge_filter_enable_q, twelve_bit_base_id_enable_q;
  logic ssp_enable_q, stamp_strobe_q, time_base_overflow_flag_q;
  logic [6:0] secondary_sample_point_q;
  logic [27:0] e;
  logic [5:0] f;
  logic [31:0] stamp = 32'h0;
  int error_cnt = 0, n_compared = 0;
  // ssp cases: expected, measured, mode, offset, value
  localparam logic [27:0] SSP_T [6] = '{{7'h09, 6'h14, 2'h1, 7'h7f, 6'h0a},
    {7'h00, 6'h00, 2'h1, 7'h40, 6'h3f}, {7'h7e, 6'h01, 2'h1, 7'h3f, 6'h3f},
    {7'h17, 6'h14, 2'h2, 7'h03, 6'h05}, {7'h26, 6'h28, 2'h3, 7'h7e, 6'h05},
    {7'h00, 6'h09, 2'h0, 7'h03, 6'h05}};
  // stamp cases: res and eof select, event kind, capture expected
  localparam logic [5:0] TS_T [8] = '{{2'h0, 3'h0, 1'h1}, {2'h0, 3'h1, 1'h0},
    {2'h0, 3'h2, 1'h0}, {2'h2, 3'h1, 1'h1}, {2'h2, 3'h0, 1'h1},
    {2'h1, 3'h2, 1'h1}, {2'h1, 3'h3, 1'h1}, {2'h1, 3'h0, 1'h0}};

  ctv_top uut (.clock, .sys_rst, .ce, .config_mode, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata_q, .measured_delay, .measure_strobe,
    .sof_sample, .fd_res_sample, .rx_frame_valid, .tx_frame_valid,
    .receive_fifo_flags, .transmit_fifo_flags, .fifo_filter_hits,
    .cause_flags, .overflow_clear, .edge_filter_enable_q,
    .twelve_bit_base_id_enable_q, .ssp_enable_q, .secondary_sample_point_q,
    .timestamp_q, .stamp_strobe_q, .time_base_overflow_flag_q, .vector_q);
  ctv_frame_model pm (.req, .kind, .delay, .sof_sample, .fd_res_sample,
    .rx_frame_valid, .tx_frame_valid, .measure_strobe, .measured_delay);

  ////////////////////////////////////////////////////////////////////////
  // free-running 8 ns clock
  initial begin
    forever #4 clock = ~clock;
  end

  task automatic chk(logic [63:0] got, logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one clock of stimulus; every strobe is set each call, so none doubles
  task automatic step(logic w, logic r, logic [2:0] ev, logic [3:0] a,
                      logic [31:0] d);
    reg_wr = w;
    reg_rd = r;
    req = ev != 3'h7;
    kind = ev;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
  endtask : step
  task automatic rd(logic [3:0] a, logic [31:0] exp);
    step(1'b0, 1'b1, 3'h7, a, 32'h0);
    chk(reg_rdata_q, exp);
  endtask : rd
  task automatic vcase(logic [31:0] rx, logic [31:0] tx, logic [9:0] cs,
                       logic [31:0] exp);
    receive_fifo_flags = rx;
    transmit_fifo_flags = tx;
    cause_flags = cs;
    step(1'b0, 1'b0, 3'h7, 4'h0, 32'h0);
    rd(CTV_OFS_VEC, exp);
    chk(vector_q, exp);
  endtask : vcase
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////
  // guard against a hang anywhere in the sequence
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge clock);
    #1 sys_rst = 1'b0;
    rd(CTV_OFS_TDC, 32'h00021000);
    rd(CTV_OFS_TSCON, 32'h0);
    rd(CTV_OFS_VEC, 32'h40400040);
    rd(4'h2, 32'h0);
    // writes outside configuration mode must bounce
    step(1'b1, 1'b0, 3'h7, CTV_OFS_TDC, 32'hffffffff);
    rd(CTV_OFS_TDC, 32'h00021000);
    config_mode = 1'b1;
    step(1'b1, 1'b0, 3'h7, CTV_OFS_TDC, 32'hffffffff);
    rd(CTV_OFS_TDC, 32'h03037f3f);
    chk({edge_filter_enable_q, twelve_bit_base_id_enable_q}, 2'h3);
    // manual ignores the measurement, auto takes it, negatives clamp
    foreach (SSP_T[i]) begin
      e = SSP_T[i];
      step(1'b1, 1'b0, 3'h7, CTV_OFS_TDC,
           {14'h0, e[14:13], 1'b0, e[12:6], 2'h0, e[5:0]});
      delay = e[20:15];
      step(1'b0, 1'b0, 3'h4, 4'h0, 32'h0);
      step(1'b0, 1'b0, 3'h7, 4'h0, 32'h0);
      chk(ssp_enable_q, e[14:13] != 2'h0);
      if (e[14:13] != 2'h0)
        chk(secondary_sample_point_q, e[27:21]);
    end
    chk({edge_filter_enable_q, twelve_bit_base_id_enable_q}, 2'h0);
    // prescale 3 gives one step per four clocks, a load restarts it
    step(1'b1, 1'b0, 3'h7, CTV_OFS_TSCON, 32'h00010003);
    for (int k = 1; k <= 8; k++) rd(CTV_OFS_TBC, (k - 1) / 4);
    step(1'b1, 1'b0, 3'h7, CTV_OFS_TBC, 32'h00000100);
    for (int k = 1; k <= 6; k++) rd(CTV_OFS_TBC, 32'h100 + (k - 1) / 4);
    rd(CTV_OFS_TSCON, 32'h00010003);
    step(1'b1, 1'b0, 3'h7, CTV_OFS_TSCON, 32'h00000003);
    step(1'b1, 1'b0, 3'h7, CTV_OFS_TBC, 32'h00000055);
    step(1'b0, 1'b0, 3'h7, 4'h0, 32'h0);
    rd(CTV_OFS_TBC, 32'h0);
    // wrap sets the sticky flag and its cause code
    step(1'b1, 1'b0, 3'h7, CTV_OFS_TSCON, 32'h00010000);
    step(1'b1, 1'b0, 3'h7, CTV_OFS_TBC, 32'hfffffffe);
    rd(CTV_OFS_TBC, 32'hfffffffe);
    rd(CTV_OFS_TBC, 32'hffffffff);
    rd(CTV_OFS_TBC, 32'h0);
    repeat (3) step(1'b0, 1'b0, 3'h7, 4'h0, 32'h0);
    chk(time_base_overflow_flag_q, 1'b1);
    chk(vector_q[6:0], 7'h46);
    overflow_clear = 1'b1;
    step(1'b0, 1'b0, 3'h7, 4'h0, 32'h0);
    overflow_clear = 1'b0;
    step(1'b0, 1'b0, 3'h7, 4'h0, 32'h0);
    chk(time_base_overflow_flag_q, 1'b0);
    // a low clock enable freezes the running counter
    step(1'b1, 1'b0, 3'h7, CTV_OFS_TBC, 32'h00000200);
    ce = 1'b0;
    repeat (3) step(1'b0, 1'b0, 3'h7, 4'h0, 32'h0);
    ce = 1'b1;
    rd(CTV_OFS_TBC, 32'h00000200);
    // sof, res and eof stamping, each against two or three event kinds
    foreach (TS_T[i]) begin
      f = TS_T[i];
      step(1'b1, 1'b0, 3'h7, CTV_OFS_TSCON, {13'h0, f[5:4], 17'h10000});
      step(1'b1, 1'b0, 3'h7, CTV_OFS_TBC, 32'h1000 * (i + 1));
      step(1'b0, 1'b0, f[3:1], 4'h0, 32'h0);
      if (f[0])
        stamp = 32'h1000 * (i + 1);
      chk({stamp_strobe_q, timestamp_q}, {f[0], stamp});
    end
    // priority of codes and the filter of the reported fifo
    vcase(32'h00000022, 32'h0, 10'h000, 32'h05401105);
    vcase(32'h00000001, 32'h1, 10'h000, 32'h40000000);
    vcase(32'h80000000, 32'h40000000, 10'h201, 32'h1f1e0b4a);
    vcase(32'h0, 32'h0, 10'h001, 32'h40400041);
    // a mid-run reset brings back the reset values
    sys_rst = 1'b1;
    step(1'b0, 1'b0, 3'h7, 4'h0, 32'h0);
    sys_rst = 1'b0;
    rd(CTV_OFS_TDC, 32'h00021000);
    rd(CTV_OFS_TBC, 32'h0);
    chk({time_base_overflow_flag_q, ssp_enable_q}, 2'h1);
    step(1'b0, 1'b0, 3'h7, 4'h0, 32'h0);
    final_report();
  end
endmodule : test_can_fd_tdc_timestamp_vector
`default_nettype wire
